// file: hw/irf_defs.svh
// constants of the interrupt request flag block
`ifndef IRF_DEFS_SVH
`define IRF_DEFS_SVH
// register indices, byte address is four times the index
`define IRF_IDX_SYSTEM      16'hF018
`define IRF_IDX_PORT_PIN    16'hF019
`define IRF_IDX_SERIAL_CONV 16'hF01A
`define IRF_IDX_TIMER       16'hF01B
`define IRF_IDX_UART_CMP    16'hF01C
`define IRF_IDX_EVT_STATUS  16'hF0F0
`define IRF_IDX_EVT_MASK    16'hF0F1
// implemented, writable bits of each request register
`define IRF_MASK_SYSTEM      8'h40
`define IRF_MASK_PORT_PIN    8'h0F
`define IRF_MASK_SERIAL_CONV 8'h87
`define IRF_MASK_TIMER       8'h1F
`define IRF_MASK_UART_CMP    8'hC3
`define IRF_RESET_VALUE      8'h00
// instruction completions that hold off entry after a write
`define IRF_HOLD_INSTR       2'h2
`endif

// file: hw/irf_pkg.sv
// types and address decoding of the interrupt request flag block
`include "irf_defs.svh"
package irf_pkg;
	// slot of a register index: 0..4 request regs, 5 status, 6 mask, 7 unmapped
	typedef logic [2:0] irf_slot_type;

	typedef struct packed {
		logic       ack;
		logic [7:0] rdat;
		logic [4:0] sts;
		logic [4:0] msk;
	} irf_state_type;

	typedef struct packed {
		logic [7:0] flags;
	} irf_flag_state_type;

	typedef struct packed {
		logic [1:0] cnt;
	} irf_hold_state_type;

	function automatic irf_slot_type irf_slot_decode(input logic [15:0] idx);
		unique case (idx)
			`IRF_IDX_SYSTEM:      irf_slot_decode = 3'h0;
			`IRF_IDX_PORT_PIN:    irf_slot_decode = 3'h1;
			`IRF_IDX_SERIAL_CONV: irf_slot_decode = 3'h2;
			`IRF_IDX_TIMER:       irf_slot_decode = 3'h3;
			`IRF_IDX_UART_CMP:    irf_slot_decode = 3'h4;
			`IRF_IDX_EVT_STATUS:  irf_slot_decode = 3'h5;
			`IRF_IDX_EVT_MASK:    irf_slot_decode = 3'h6;
			default:              irf_slot_decode = 3'h7;
		endcase
	endfunction
endpackage

// file: hw/irf_flag_reg.sv
// one 8-bit request register with hardware set, software write and accept clear
`timescale 1ns/1ns
`default_nettype none
`include "irf_defs.svh"
module irf_flag_reg #(
	parameter logic [7:0] WMASK = 8'hFF
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] set_i,
	input  wire logic [7:0] clr_i,
	output logic      [7:0] flags_o
);
	irf_pkg::irf_flag_state_type s_q;
	irf_pkg::irf_flag_state_type s_d;

	// clears first, then sets, so any set in the same cycle wins
	always_comb begin
		s_d.flags = s_q.flags & ~clr_i;
		if (wr_i) begin
			s_d.flags = (s_d.flags & ~WMASK) | (wdata_i & WMASK);
		end
		s_d.flags = (s_d.flags | set_i) & WMASK;
	end

	// register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.flags <= `IRF_RESET_VALUE;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_o = s_q.flags;
endmodule
`default_nettype wire

// file: hw/irf_entry_hold.sv
// holds off interrupt entry until enough instructions completed after a write
`timescale 1ns/1ns
`default_nettype none
`include "irf_defs.svh"
module irf_entry_hold (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	input  wire logic instr_done_i,
	output logic      hold_o
);
	irf_pkg::irf_hold_state_type s_q;
	irf_pkg::irf_hold_state_type s_d;

	// the write itself completes, then one further instruction must
	always_comb begin
		s_d = s_q;
		if (start_i) begin
			s_d.cnt = `IRF_HOLD_INSTR;
		end else if (instr_done_i && s_q.cnt != 2'h0) begin
			s_d.cnt = s_q.cnt - 2'h1;
		end
	end

	// register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.cnt <= 2'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hold_o = (s_q.cnt != 2'h0);
endmodule
`default_nettype wire

// file: hw/irf_top.sv
// interrupt request flags with wishbone access and cpu request/accept port
`timescale 1ns/1ns
`default_nettype none
`include "irf_defs.svh"
// How it works
// - a source event sets its flag regardless of enables
// - request to cpu only when flag, its enable and master enable are all set
// - software writing 1 to an implemented flag sets it like an event
// - cpu accepting a source clears only that flag
// - after a request or enable write, entry waits one further instruction
// - bit 6 of the system register holds the slow clock change request
// - port pin register bits 0 to 3 hold pin 0 to 3 requests
// - serial/converter register: serial 0, serial 1, converter, bit 7 two-wire
// - timer register: timers 0, 1, 8, 9 in bits 0-3, bit 4 spare storage
// - uart/comparator register: uart 0, uart 1, bit 6 comparator 0
// - every request register is 8 bits and resets to zero
// - bit 7 of uart/comparator register holds comparator 1 request
module irf_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [17:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic [16:0] src_event_i,
	input  wire logic [16:0] src_enable_i,
	input  wire logic        master_interrupt_enable_i,
	input  wire logic        enable_write_i,
	input  wire logic        instr_done_i,
	input  wire logic        accept_i,
	input  wire logic [4:0]  accept_src_i,
	output logic      [16:0] cpu_request_o,
	output logic             irq_o
);
	localparam int NSRC = 17;

	// register bit (slot*8+bit) that holds each source, in source order
	localparam logic [5:0] SRC_POS [NSRC] = '{
		6'd6,                          // slow_clock_change_request
		6'd8, 6'd9, 6'd10, 6'd11,      // port_pin0..3_request
		6'd16, 6'd17, 6'd18, 6'd23,    // sync_serial0/1, sar_converter, two_wire_serial
		6'd24, 6'd25, 6'd26, 6'd27,    // timer0, timer1, timer8, timer9
		6'd32, 6'd33, 6'd38, 6'd39     // uart0, uart1, comparator0, comparator1
	};
	localparam logic [7:0] WMASKS [5] = '{
		`IRF_MASK_SYSTEM, `IRF_MASK_PORT_PIN, `IRF_MASK_SERIAL_CONV,
		`IRF_MASK_TIMER, `IRF_MASK_UART_CMP
	};
	localparam logic [39:0] IMPL = {`IRF_MASK_UART_CMP, `IRF_MASK_TIMER,
		`IRF_MASK_SERIAL_CONV, `IRF_MASK_PORT_PIN, `IRF_MASK_SYSTEM};

	irf_pkg::irf_state_type s_q;
	irf_pkg::irf_state_type s_d;
	irf_pkg::irf_slot_type  slot;
	logic [39:0]            flags;
	logic [39:0]            hw_set;
	logic [39:0]            acc_clr;
	logic [4:0]             grp_evt;
	logic [16:0]            pend;
	logic                   hold;
	logic                   req_go;
	logic                   fire;
	logic                   fire_wr;
	logic                   req_wr;
	logic [1:0]             chk_done_q;

	// bus request is taken at the edge where ack is high
	assign slot    = irf_pkg::irf_slot_decode(adr_i[17:2]);
	assign req_go  = cyc_i && stb_i;
	assign fire    = req_go && s_q.ack;
	assign fire_wr = fire && we_i && sel_i[0];
	assign req_wr  = fire_wr && (slot < 3'h5);

	// map source events and the accepted source onto register bits
	always_comb begin
		hw_set  = '0;
		acc_clr = '0;
		pend    = '0;
		grp_evt = '0;
		for (int s = 0; s < NSRC; s++) begin
			hw_set[SRC_POS[s]] = src_event_i[s];
			if (accept_i && accept_src_i == 5'(s)) begin
				acc_clr[SRC_POS[s]] = 1'b1;
			end
			pend[s] = flags[SRC_POS[s]];
			grp_evt[SRC_POS[s][5:3]] = grp_evt[SRC_POS[s][5:3]] | src_event_i[s];
		end
	end

	// the five request registers, one per slot
	for (genvar g = 0; g < 5; g++) begin : g_req
		irf_flag_reg #(
			.WMASK(WMASKS[g])
		) u_reg (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.wr_i   (req_wr && slot == 3'(g)),
			.wdata_i(dat_i[7:0]),
			.set_i  (hw_set[g*8 +: 8]),
			.clr_i  (acc_clr[g*8 +: 8]),
			.flags_o(flags[g*8 +: 8])
		);
	end

	// entry hold-off after a request or enable write
	irf_entry_hold u_hold (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.start_i     (req_wr || enable_write_i),
		.instr_done_i(instr_done_i),
		.hold_o      (hold)
	);

	// request to the cpu needs flag, source enable and master enable
	assign cpu_request_o = (hold || !master_interrupt_enable_i) ? '0 : (pend & src_enable_i);

	// bus slave, event status and mask
	always_comb begin
		s_d     = s_q;
		s_d.ack = req_go && !s_q.ack;
		if (req_go && !s_q.ack) begin
			unique case (slot)
				3'h5:    s_d.rdat = {3'h0, s_q.sts};
				3'h6:    s_d.rdat = {3'h0, s_q.msk};
				3'h7:    s_d.rdat = 8'h00;
				default: s_d.rdat = flags[slot*8 +: 8];
			endcase
		end
		if (fire && !we_i && slot == 3'h5) begin
			s_d.sts = s_q.sts & ~s_q.rdat[4:0]; // only bits actually returned
		end
		if (fire_wr && slot == 3'h6) begin
			s_d.msk = dat_i[4:0];
		end
		s_d.sts = s_d.sts | grp_evt; // event beats read clear
	end

	// register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q.ack  <= 1'b0;
			s_q.rdat <= 8'h00;
			s_q.sts  <= 5'h00;
			s_q.msk  <= 5'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign ack_o = s_q.ack;
	assign dat_o = {24'h000000, s_q.rdat};
	assign irq_o = |(s_q.sts & s_q.msk);

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_req_write;
		req_wr;
	endsequence

	sequence s_blocked;
		cpu_request_o == 17'h0;
	endsequence

	sequence s_read_of(logic [2:0] k);
		req_go && !s_q.ack && !we_i && slot == k;
	endsequence

	// completions seen since the last request or enable write, saturating at two
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chk_done_q <= 2'h2;
		end else if (req_wr || enable_write_i) begin
			chk_done_q <= 2'h0;
		end else if (instr_done_i && chk_done_q != 2'h2) begin
			chk_done_q <= chk_done_q + 2'h1;
		end
	end

	property p_event_sets;
		(|hw_set) |=> ((($past(hw_set)) & ~flags) == 40'h0);
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

	property p_set_wins;
		((|hw_set) && (req_wr || accept_i)) |=> ((($past(hw_set)) & ~flags) == 40'h0);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

	property p_gate;
		(|cpu_request_o) |-> (master_interrupt_enable_i && !hold
			&& ((cpu_request_o & ~(pend & src_enable_i)) == 17'h0));
	endproperty
	a_gate: assert property (p_gate) else $error("request without enables");

	property p_sw_set;
		(req_wr && slot == 3'h1) |=> ((flags[15:8] & ($past(dat_i[7:0]) & 8'h0F))
			== ($past(dat_i[7:0]) & 8'h0F));
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set lost");

	property p_accept_clear;
		(accept_i && accept_src_i == 5'd13 && !src_event_i[13] && !req_wr)
			|=> (!flags[32] && flags[39:33] == $past(flags[39:33] | hw_set[39:33]));
	endproperty
	a_accept_clear: assert property (p_accept_clear) else $error("accept clear wrong");

	property p_hold;
		s_req_write |=> s_blocked;
	endproperty
	a_hold: assert property (p_hold) else $error("entry before next instruction");

	property p_slow_bit;
		src_event_i[0] |=> flags[6] ##0 pend[0];
	endproperty
	a_slow_bit: assert property (p_slow_bit) else $error("slow clock flag not at bit 6");

	property p_cmp1_bit;
		src_event_i[16] |=> flags[39];
	endproperty
	a_cmp1_bit: assert property (p_cmp1_bit) else $error("comparator 1 not at bit 7");

	property p_read_map;
		(req_go && !s_q.ack && !we_i && slot == 3'h3) |=> (ack_o && dat_o[7:0] == $past(flags[31:24]));
	endproperty
	a_read_map: assert property (p_read_map) else $error("timer register read wrong");

	property p_ro_zero;
		(flags & ~IMPL) == 40'h0;
	endproperty
	a_ro_zero: assert property (p_ro_zero) else $error("unimplemented bit set");

	property p_reset;
		@(posedge clk_i) disable iff (1'b0) rst_i |=> (flags == 40'h0 && !ack_o && !irq_o);
	endproperty
	a_reset: assert property (p_reset) else $error("flags not cleared by reset");

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_hold_count;
		(chk_done_q != 2'h2) |-> s_blocked;
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("request while held");

	property p_hold_release;
		(chk_done_q == 2'h2 && master_interrupt_enable_i)
			|-> (cpu_request_o == (pend & src_enable_i));
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("held too long");

	property p_enable_write;
		enable_write_i |=> s_blocked;
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write not held");

	property p_mie_off;
		!master_interrupt_enable_i |-> s_blocked;
	endproperty
	a_mie_off: assert property (p_mie_off) else $error("request with master off");

	property p_src_enable;
		(cpu_request_o & ~src_enable_i) == 17'h0;
	endproperty
	a_src_enable: assert property (p_src_enable) else $error("request of disabled source");

	property p_port_read;
		s_read_of(3'h1) |=> (dat_o[7:0] == $past(flags[15:8]));
	endproperty
	a_port_read: assert property (p_port_read) else $error("port pin read wrong");

	property p_serial_read;
		s_read_of(3'h2) |=> (dat_o[7:0] == $past(flags[23:16]));
	endproperty
	a_serial_read: assert property (p_serial_read) else $error("serial read wrong");

	property p_uart_read;
		s_read_of(3'h4) |=> (dat_o[7:0] == $past(flags[39:32]));
	endproperty
	a_uart_read: assert property (p_uart_read) else $error("uart read wrong");

	property p_sys_read;
		s_read_of(3'h0) |=> (dat_o[7:0] == $past(flags[7:0]));
	endproperty
	a_sys_read: assert property (p_sys_read) else $error("system read wrong");

	property p_unmapped_read;
		s_read_of(3'h7) |=> (dat_o == 32'h00000000);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_sw_set_serial;
		(req_wr && slot == 3'h2) |=> ((flags[23:16] & $past(dat_i[7:0]) & `IRF_MASK_SERIAL_CONV)
			== ($past(dat_i[7:0]) & `IRF_MASK_SERIAL_CONV));
	endproperty
	a_sw_set_serial: assert property (p_sw_set_serial) else $error("serial set lost");

	property p_sw_set_timer;
		(req_wr && slot == 3'h3) |=> ((flags[31:24] & $past(dat_i[7:0]) & `IRF_MASK_TIMER)
			== ($past(dat_i[7:0]) & `IRF_MASK_TIMER));
	endproperty
	a_sw_set_timer: assert property (p_sw_set_timer) else $error("timer set lost");

	property p_sw_set_uart;
		(req_wr && slot == 3'h4) |=> ((flags[39:32] & $past(dat_i[7:0]) & `IRF_MASK_UART_CMP)
			== ($past(dat_i[7:0]) & `IRF_MASK_UART_CMP));
	endproperty
	a_sw_set_uart: assert property (p_sw_set_uart) else $error("uart set lost");

	property p_sw_clear;
		(req_wr && slot == 3'h1 && !(|hw_set[15:8]))
			|=> ((flags[15:8] & ~$past(dat_i[7:0])) == 8'h00);
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("software clear lost");

	property p_flags_hold;
		(!(|hw_set) && !req_wr && !accept_i) |=> $stable(flags);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flag changed without cause");

	property p_accept_slow;
		(accept_i && accept_src_i == 5'h00 && !src_event_i[0] && !req_wr) |=> !flags[6];
	endproperty
	a_accept_slow: assert property (p_accept_slow) else $error("slow flag not cleared");

	property p_accept_timer9;
		(accept_i && accept_src_i == 5'h0C && !src_event_i[12] && !req_wr) |=> !flags[27];
	endproperty
	a_accept_timer9: assert property (p_accept_timer9) else $error("timer9 not cleared");

	property p_status_set;
		(|grp_evt) |=> (($past(grp_evt) & ~s_q.sts) == 5'h00);
	endproperty
	a_status_set: assert property (p_status_set) else $error("status bit not set");

	property p_status_clear;
		(fire && !we_i && slot == 3'h5 && !(|grp_evt))
			|=> ((s_q.sts & $past(s_q.rdat[4:0])) == 5'h00);
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared by read");

	property p_mask_write;
		(fire_wr && slot == 3'h6) |=> (s_q.msk == $past(dat_i[4:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	property p_ack_answer;
		(req_go && !ack_o) |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

	property p_dat_high;
		dat_o[31:8] == 24'h000000;
	endproperty
	a_dat_high: assert property (p_dat_high) else $error("upper read data not zero");
endmodule
`default_nettype wire

// file: test/irf_cpu_model.sv
// cpu core model: instruction completions and request acceptance
`timescale 1ns/1ns
`default_nettype none
module irf_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        step_i,
	input  wire logic        take_i,
	input  wire logic [16:0] cpu_request_i,
	output logic             instr_done_o,
	output logic             accept_o,
	output logic      [4:0]  accept_src_o
);
	logic [4:0] low;
	// lowest pending request is the one taken
	always_comb begin
		low = 5'h00;
		for (int i = 16; i >= 0; i--) begin
			if (cpu_request_i[i]) low = i[4:0];
		end
	end
	// one completion per step, one accept pulse per take
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr_done_o <= 1'b0;
			accept_o     <= 1'b0;
			accept_src_o <= 5'h00;
		end else begin
			instr_done_o <= step_i;
			accept_o     <= take_i & |cpu_request_i & ~accept_o;
			accept_src_o <= low;
		end
	end
endmodule
`default_nettype wire

// file: test/interrupt_request_flags_test.sv
// self-checking bench of the interrupt request flag block
`timescale 1ns/1ns
`default_nettype none
`include "irf_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module interrupt_request_flags_test;
	logic        clk, rst, cyc, stb, we, master_interrupt_enable, enw, done, acc, step, take, ack, irq;
	logic [17:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [16:0] ev, en, req;
	logic [4:0]  asrc;
	logic [7:0]  q;
	int          num_errors, check_count, cycles;
	logic [7:0]  wmask [5] = '{`IRF_MASK_SYSTEM, `IRF_MASK_PORT_PIN, `IRF_MASK_SERIAL_CONV,
		`IRF_MASK_TIMER, `IRF_MASK_UART_CMP};
	logic [2:0]  sbit [17] = '{3'h6, 3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h2, 3'h7,
		3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7};
	irf_top u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .src_event_i(ev), .src_enable_i(en),
		.master_interrupt_enable_i(master_interrupt_enable), .enable_write_i(enw), .instr_done_i(done),
		.accept_i(acc), .accept_src_i(asrc), .cpu_request_o(req), .irq_o(irq));
	irf_cpu_model u_cpu (.clk_i(clk), .rst_i(rst), .step_i(step), .take_i(take),
		.cpu_request_i(req), .instr_done_o(done), .accept_o(acc), .accept_src_o(asrc));
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	// one classic wishbone cycle, read data taken at the edge that samples ack high
	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		`CHK("read", e, q)
	endtask
	task automatic evp(input int s);
		@(posedge clk);
		ev <= 17'h00001 << s;
		@(posedge clk);
		ev <= 17'h00000;
		@(negedge clk);
	endtask
	// one instruction completed, or one request accepted, by the cpu model
	task automatic cpu(input logic a);
		@(posedge clk);
		if (a) take <= 1'b1;
		else step <= 1'b1;
		@(posedge clk);
		take <= 1'b0;
		step <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			rd(16'(16'hF018 + i), 8'h00);
			wb(1'b1, 16'(16'hF018 + i), 8'hFF);
			rd(16'(16'hF018 + i), wmask[i]);
			wb(1'b1, 16'(16'hF018 + i), 8'h00);
			rd(16'(16'hF018 + i), 8'h00);
		end
		wb(1'b1, 16'h0100, 8'hFF);
		rd(16'h0100, 8'h00);
	endtask
	task automatic t_sources();
		int slot;
		cpu(1'b0);
		cpu(1'b0);
		for (int s = 0; s < 17; s++) begin
			slot = (s == 0) ? 0 : (s - 1) / 4 + 1;
			evp(s);
			rd(16'(16'hF018 + slot), 8'h01 << sbit[s]);
			`CHK("req off", 17'h00000, req)
			en <= 17'h00001 << s;
			@(posedge clk);
			`CHK("req mie off", 17'h00000, req)
			master_interrupt_enable <= 1'b1;
			@(posedge clk);
			`CHK("req on", 17'h00001 << s, req)
			cpu(1'b1);
			rd(16'(16'hF018 + slot), 8'h00);
			master_interrupt_enable <= 1'b0;
		end
	endtask
	task automatic t_hold();
		@(posedge clk);
		en <= 17'h1FFFF;
		master_interrupt_enable <= 1'b1;
		wb(1'b1, 16'hF019, 8'h03);
		@(negedge clk);
		`CHK("hold 2", 17'h00000, req)
		cpu(1'b0);
		`CHK("hold 1", 17'h00000, req)
		cpu(1'b0);
		`CHK("hold 0", 17'h00006, req)
		@(posedge clk);
		enw <= 1'b1;
		@(posedge clk);
		enw <= 1'b0;
		@(negedge clk);
		`CHK("hold en", 17'h00000, req)
		cpu(1'b0);
		cpu(1'b0);
		cpu(1'b1);
		rd(16'hF019, 8'h02);
		@(posedge clk);
		ev <= 17'h00001 << 13;
		wb(1'b1, 16'hF01C, 8'h00);
		ev <= 17'h00000;
		rd(16'hF01C, 8'h01);
	endtask
	task automatic t_irq();
		wb(1'b1, 16'hF0F1, 8'h02);
		rd(16'hF0F1, 8'h02);
		wb(1'b0, 16'hF0F0, 8'h00);
		@(negedge clk);
		`CHK("irq idle", 1'b0, irq)
		evp(3);
		evp(9);
		@(negedge clk);
		`CHK("irq set", 1'b1, irq)
		rd(16'hF0F0, 8'h0A);
		evp(10);
		@(negedge clk);
		`CHK("irq masked", 1'b0, irq)
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		{rst, cyc, stb, we, master_interrupt_enable, enw, step, take} = 8'h80;
		{adr, sel, wdat, ev, en} = '0;
		sel = 4'hF;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_sources();
		t_hold();
		t_irq();
		finish_test();
	end
endmodule
`default_nettype wire
